// ---- tws_pkg.sv ----
/*
  Constants, register layout, status codes and types of the two-wire slave block.
  Assumes a Wishbone register port with 32-bit data and byte lane 0 carrying every register.
*/
package tws_pkg;

  // Register offsets (byte addresses)
  localparam logic [3:0] OFS_OWN_ADDR = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h8;
  localparam logic [3:0] OFS_DATA = 4'hc;

  // Control register bit positions
  localparam int CTL_FLAG = 7;
  localparam int CTL_ACK = 6;
  localparam int CTL_STA = 5;
  localparam int CTL_STO = 4;
  localparam int CTL_WC = 3;
  localparam int CTL_EN = 2;
  localparam int CTL_IE = 0;

  // Status register fields
  localparam logic [7:0] STATUS_CODE_MASK = 8'hf8;
  localparam logic [7:0] PRESC_MASK = 8'h03;

  // Reset values
  localparam logic [7:0] OWN_ADDR_RST = 8'h00;
  localparam logic [7:0] DATA_RST = 8'hff;
  localparam logic [1:0] PRESC_RST = 2'h0;

  // Bus constants
  localparam logic [6:0] GC_ADDR = 7'h00;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] LAST_BIT = 4'h7;

  // Status codes
  localparam logic [7:0] SC_RX_ADDR = 8'h60;
  localparam logic [7:0] SC_RX_ADDR_ARB = 8'h68;
  localparam logic [7:0] SC_RX_GC = 8'h70;
  localparam logic [7:0] SC_RX_GC_ARB = 8'h78;
  localparam logic [7:0] SC_RX_DATA_ACK = 8'h80;
  localparam logic [7:0] SC_RX_DATA_NACK = 8'h88;
  localparam logic [7:0] SC_GC_DATA_ACK = 8'h90;
  localparam logic [7:0] SC_GC_DATA_NACK = 8'h98;
  localparam logic [7:0] SC_RX_STOP = 8'ha0;
  localparam logic [7:0] SC_TX_ADDR = 8'ha8;
  localparam logic [7:0] SC_TX_ADDR_ARB = 8'hb0;
  localparam logic [7:0] SC_TX_DATA_ACK = 8'hb8;
  localparam logic [7:0] SC_TX_DATA_NACK = 8'hc0;
  localparam logic [7:0] SC_TX_LAST_ACK = 8'hc8;
  localparam logic [7:0] SC_NO_INFO = 8'hf8;

  typedef struct packed {
    logic flag;
    logic ack;
    logic sta;
    logic sto;
    logic wc;
    logic en;
    logic ie;
  } tws_control_t;

  typedef enum logic [2:0] {
    MODE_RX,
    MODE_TX,
    MODE_DONE
  } tws_mode_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_ADDR,
    S_ADDR_ACK,
    S_RX,
    S_RX_ACK,
    S_TX,
    S_TX_ACK,
    S_WAIT
  } tws_state_t;

endpackage

// ---- tws_slave.sv ----
/*
  Two-wire serial slave: own-address and general-call recognition, slave receiver and
  slave transmitter with status codes, clock stretching and sleep wake-up, plus a
  classic Wishbone register slave.
  Assumes open-drain pins resolved outside, a system clock far faster than the bus
  clock, and master-mode logic elsewhere that consumes o_start_request.
*/
`timescale 1ns/1ns

module tws_slave #(
  parameter int ADR_W = 4
) (
  // System
  input wire logic i_clock,
  input wire logic i_rstn,
  // Wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_sel,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // Two-wire bus pins
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda_out,
  output logic o_sda_oe,
  // System side
  input wire logic i_sleep,
  input wire logic i_arb_lost,
  output logic o_wake,
  output logic o_start_request
);

  if (ADR_W < 4) begin : g_check
    $error("ADR_W must be at least 4");
  end

  tws_pkg::tws_control_t ctl;
  tws_pkg::tws_state_t state;
  tws_pkg::tws_mode_t mode;
  logic [7:0] own_slave_address;
  logic [7:0] serial_data_register;
  logic [7:0] status_code;
  logic [1:0] presc;
  logic [7:0] shift;
  logic [3:0] cnt;
  logic gc;
  logic last;
  logic master_ack;
  logic set_evt;
  logic [7:0] evt_code;
  logic rx_load;
  logic start_pending;
  logic bus_free;
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;

  // Pin synchronisers; stage 0 feeds stage 1 only
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], i_scl};
      sda_sync <= {sda_sync[1:0], i_sda};
    end
  end

  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  assign scl = scl_sync[1];
  assign sda = sda_sync[1];
  assign scl_rise = scl & ~scl_sync[2];
  assign scl_fall = ~scl & scl_sync[2];
  assign bus_start = scl & scl_sync[2] & ~sda & sda_sync[2];
  assign bus_stop = scl & scl_sync[2] & sda & ~sda_sync[2];

  // Register decode
  logic wb_req;
  logic wr;
  logic upper_zero;
  logic wr_own;
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data;
  logic sw_clear;
  assign wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr = wb_req & i_wb_we & i_wb_sel[0];
  assign upper_zero = (i_wb_adr >> 4) == '0;
  assign wr_own = wr & upper_zero & (i_wb_adr[3:0] == tws_pkg::OFS_OWN_ADDR);
  assign wr_ctrl = wr & upper_zero & (i_wb_adr[3:0] == tws_pkg::OFS_CONTROL);
  assign wr_stat = wr & upper_zero & (i_wb_adr[3:0] == tws_pkg::OFS_STATUS);
  assign wr_data = wr & upper_zero & (i_wb_adr[3:0] == tws_pkg::OFS_DATA);
  assign sw_clear = wr_ctrl & i_wb_dat[tws_pkg::CTL_FLAG] & ctl.flag;

  // Own address or general call, gated live by ack enable
  function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] own,
                                      input logic ack_en);
    addr_match = ack_en & ((rx[7:1] == own[7:1]) |
                 (own[0] & (rx[7:1] == tws_pkg::GC_ADDR)));
  endfunction

  // Wishbone answer: one wait state, unmapped reads give zero
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= wb_req;
      o_wb_dat <= 32'h0000_0000;
      if (wb_req && !i_wb_we && upper_zero) begin
        case (i_wb_adr[3:0])
          tws_pkg::OFS_OWN_ADDR: o_wb_dat[7:0] <= own_slave_address;
          tws_pkg::OFS_CONTROL: o_wb_dat[7:0] <= {ctl.flag, ctl.ack, ctl.sta, ctl.sto,
                                                 ctl.wc, ctl.en, 1'b0, ctl.ie};
          tws_pkg::OFS_STATUS: o_wb_dat[7:0] <= (ctl.flag ? status_code : tws_pkg::SC_NO_INFO)
                                                | {6'h00, presc};
          tws_pkg::OFS_DATA: o_wb_dat[7:0] <= serial_data_register;
          default: o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      own_slave_address <= tws_pkg::OWN_ADDR_RST;
      presc <= tws_pkg::PRESC_RST;
    end else begin
      if (wr_own) begin
        own_slave_address <= i_wb_dat[7:0];
      end
      if (wr_stat) begin
        presc <= i_wb_dat[1:0];
      end
    end
  end

  // Control register; a hardware event beats a same-cycle software clear
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      ctl <= '0;
    end else begin
      if (wr_ctrl) begin
        ctl.ack <= i_wb_dat[tws_pkg::CTL_ACK];
        ctl.sta <= i_wb_dat[tws_pkg::CTL_STA];
        ctl.sto <= i_wb_dat[tws_pkg::CTL_STO] & ~i_wb_dat[tws_pkg::CTL_FLAG];
        ctl.en <= i_wb_dat[tws_pkg::CTL_EN];
        ctl.ie <= i_wb_dat[tws_pkg::CTL_IE];
      end
      ctl.flag <= set_evt | (ctl.flag & ~sw_clear);
      if (wr_data && !ctl.flag) begin
        ctl.wc <= 1'b1;
      end else if (wr_data) begin
        ctl.wc <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      status_code <= tws_pkg::SC_NO_INFO;
    end else if (set_evt) begin
      status_code <= evt_code & tws_pkg::STATUS_CODE_MASK;
    end
  end

  // Address bytes never reach the data register, even when caught in sleep
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      serial_data_register <= tws_pkg::DATA_RST;
    end else if (rx_load) begin
      serial_data_register <= shift;
    end else if (wr_data && ctl.flag) begin
      serial_data_register <= i_wb_dat[7:0];
    end
  end

  // Slave protocol engine
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      state <= tws_pkg::S_IDLE;
      mode <= tws_pkg::MODE_DONE;
      shift <= 8'h00;
      cnt <= 4'h0;
      gc <= 1'b0;
      last <= 1'b0;
      master_ack <= 1'b0;
      set_evt <= 1'b0;
      evt_code <= tws_pkg::SC_NO_INFO;
      rx_load <= 1'b0;
      o_sda_oe <= 1'b0;
      o_scl_oe <= 1'b0;
    end else begin
      set_evt <= 1'b0;
      rx_load <= 1'b0;
      if (!ctl.en || (wr_ctrl && i_wb_dat[tws_pkg::CTL_STO] && i_wb_dat[tws_pkg::CTL_FLAG])) begin
        state <= tws_pkg::S_IDLE;
        mode <= tws_pkg::MODE_DONE;
        o_sda_oe <= 1'b0;
        o_scl_oe <= 1'b0;
      end else if (bus_start || bus_stop) begin
        if (mode == tws_pkg::MODE_RX && state != tws_pkg::S_IDLE && state != tws_pkg::S_ADDR) begin
          set_evt <= 1'b1;
          evt_code <= tws_pkg::SC_RX_STOP;
        end
        mode <= tws_pkg::MODE_DONE;
        state <= bus_start ? tws_pkg::S_ADDR : tws_pkg::S_IDLE;
        cnt <= 4'h0;
        o_sda_oe <= 1'b0;
        o_scl_oe <= 1'b0;
      end else begin
        case (state)
          tws_pkg::S_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          tws_pkg::S_ADDR, tws_pkg::S_RX: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda};
              cnt <= cnt + 4'h1;
            end else if (scl_fall && cnt == tws_pkg::BYTE_BITS) begin
              if (state == tws_pkg::S_ADDR) begin
                if (addr_match(shift, own_slave_address, ctl.ack)) begin
                  gc <= shift[7:1] == tws_pkg::GC_ADDR;
                  o_sda_oe <= 1'b1;
                  state <= tws_pkg::S_ADDR_ACK;
                end else begin
                  state <= tws_pkg::S_IDLE;
                end
              end else begin
                rx_load <= 1'b1;
                master_ack <= ctl.ack;
                o_sda_oe <= ctl.ack;
                state <= tws_pkg::S_RX_ACK;
              end
            end
          end
          tws_pkg::S_ADDR_ACK: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              set_evt <= 1'b1;
              o_scl_oe <= 1'b1;
              state <= tws_pkg::S_WAIT;
              if (shift[0]) begin
                mode <= tws_pkg::MODE_TX;
                evt_code <= i_arb_lost ? tws_pkg::SC_TX_ADDR_ARB : tws_pkg::SC_TX_ADDR;
              end else begin
                mode <= tws_pkg::MODE_RX;
                if (gc) begin
                  evt_code <= i_arb_lost ? tws_pkg::SC_RX_GC_ARB : tws_pkg::SC_RX_GC;
                end else begin
                  evt_code <= i_arb_lost ? tws_pkg::SC_RX_ADDR_ARB : tws_pkg::SC_RX_ADDR;
                end
              end
            end
          end
          tws_pkg::S_RX_ACK: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              set_evt <= 1'b1;
              o_scl_oe <= 1'b1;
              state <= tws_pkg::S_WAIT;
              if (!master_ack) begin
                mode <= tws_pkg::MODE_DONE;
              end
              if (gc) begin
                evt_code <= master_ack ? tws_pkg::SC_GC_DATA_ACK
                                       : tws_pkg::SC_GC_DATA_NACK;
              end else begin
                evt_code <= master_ack ? tws_pkg::SC_RX_DATA_ACK
                                       : tws_pkg::SC_RX_DATA_NACK;
              end
            end
          end
          tws_pkg::S_TX: begin
            if (scl_fall) begin
              if (cnt == tws_pkg::LAST_BIT) begin
                o_sda_oe <= 1'b0;
                state <= tws_pkg::S_TX_ACK;
              end else begin
                shift <= {shift[6:0], 1'b0};
                o_sda_oe <= ~shift[6];
                cnt <= cnt + 4'h1;
              end
            end
          end
          tws_pkg::S_TX_ACK: begin
            if (scl_rise) begin
              master_ack <= ~sda;
            end else if (scl_fall) begin
              set_evt <= 1'b1;
              o_scl_oe <= 1'b1;
              state <= tws_pkg::S_WAIT;
              if (!master_ack) begin
                evt_code <= tws_pkg::SC_TX_DATA_NACK;
                mode <= tws_pkg::MODE_DONE;
              end else if (last) begin
                evt_code <= tws_pkg::SC_TX_LAST_ACK;
                mode <= tws_pkg::MODE_DONE;
              end else begin
                evt_code <= tws_pkg::SC_TX_DATA_ACK;
              end
            end
          end
          tws_pkg::S_WAIT: begin
            if (sw_clear) begin
              o_scl_oe <= 1'b0;
              cnt <= 4'h0;
              case (mode)
                tws_pkg::MODE_TX: begin
                  shift <= serial_data_register;
                  o_sda_oe <= ~serial_data_register[7];
                  last <= ~i_wb_dat[tws_pkg::CTL_ACK];
                  state <= tws_pkg::S_TX;
                end
                tws_pkg::MODE_RX: begin
                  state <= tws_pkg::S_RX;
                end
                default: begin
                  state <= tws_pkg::S_IDLE;
                end
              endcase
            end
          end
          default: begin
            state <= tws_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // Start request held over the unaddressed return until the bus is free
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      bus_free <= 1'b1;
      start_pending <= 1'b0;
      o_start_request <= 1'b0;
    end else begin
      if (bus_stop) begin
        bus_free <= 1'b1;
      end else if (bus_start) begin
        bus_free <= 1'b0;
      end
      if (sw_clear && mode == tws_pkg::MODE_DONE && i_wb_dat[tws_pkg::CTL_STA]) begin
        start_pending <= 1'b1;
      end else if (!ctl.sta || bus_start) begin
        start_pending <= 1'b0;
      end
      o_start_request <= start_pending & bus_free & ctl.sta & ctl.en;
    end
  end

  // Wake stays until software clears the flag, like the stretched clock
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_wake <= 1'b0;
    end else if (state == tws_pkg::S_ADDR_ACK && i_sleep) begin
      o_wake <= 1'b1;
    end else if (sw_clear || !ctl.en) begin
      o_wake <= 1'b0;
    end
  end

  // Open-drain pins only ever pull low
  always_ff @(posedge i_clock) begin
    if (!i_rstn) begin
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
    end else begin
      o_scl_out <= 1'b0;
      o_sda_out <= 1'b0;
    end
  end

endmodule // tws_slave

// ---- tws_slave_asserts.sv ----
/*
  Checker for the two-wire slave: bus answers, stretching, wake and pin use.
  Assumes only the slave's ports; bound to every slave instance below.
*/
`timescale 1ns/1ns
module tws_slave_asserts #(
  parameter int ADR_W = 4
) (
  // System
  input wire logic i_clock,
  input wire logic i_rstn,
  // Wishbone
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_sel,
  input wire logic [ADR_W-1:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  // Bus pins
  input wire logic i_scl,
  input wire logic o_scl_out,
  input wire logic o_scl_oe,
  input wire logic i_sda,
  input wire logic o_sda_out,
  input wire logic o_sda_oe,
  // System side
  input wire logic i_sleep,
  input wire logic o_wake,
  input wire logic o_start_request
);
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rstn);
  logic clr_wr;
  logic st_rd;
  // Seen at the answer: the master holds the request until then
  assign clr_wr = i_wb_cyc && i_wb_stb && i_wb_we && i_wb_sel[0] && o_wb_ack &&
    i_wb_adr == ADR_W'(tws_pkg::OFS_CONTROL) && i_wb_dat[tws_pkg::CTL_FLAG];
  assign st_rd = o_wb_ack && !i_wb_we && i_wb_adr == ADR_W'(tws_pkg::OFS_STATUS);
  a_req_answer: assert property (
    i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack ##1 !o_wb_ack)
    else $error("bus request not answered by one pulse");
  a_read_clean: assert property (
    o_wb_ack && !i_wb_we |-> o_wb_dat[31:8] == 24'h0 && !(st_rd && o_wb_dat[2]))
    else $error("read data has stray bits");
  a_clear_release: assert property (clr_wr |-> ##[0:2] !o_scl_oe)
    else $error("clock still held after flag clear");
  a_wake_stretch: assert property (
    $rose(o_wake) |-> $past(i_sleep) ##[0:20] o_scl_oe)
    else $error("wake without sleep or without clock hold");
  a_stretch_low: assert property ($rose(o_scl_oe) |-> !i_scl)
    else $error("clock hold began while clock high");
  a_sda_edge: assert property ($changed(o_sda_oe) |-> !$past(i_scl))
    else $error("data line changed while clock high");
  a_open_drain: assert property (o_scl_out == 1'b0 && o_sda_out == 1'b0)
    else $error("pin driven high");
  a_start_free: assert property (
    $rose(o_start_request) |-> i_scl && i_sda && $past(i_sda))
    else $error("start requested on a busy bus");
  c_wake: cover property ($rose(o_wake));
  c_start: cover property ($rose(o_start_request));
  c_hold: cover property (o_scl_oe [*4]);
endmodule // tws_slave_asserts

bind tws_slave tws_slave_asserts #(.ADR_W(ADR_W)) u_asserts (
  .i_clock, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_sel, .i_wb_adr,
  .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_scl, .o_scl_out, .o_scl_oe, .i_sda,
  .o_sda_out, .o_sda_oe, .i_sleep, .o_wake, .o_start_request);

// ---- tws_master_model.sv ----
/*
  Behavioural bus master: start, stop, byte out and byte in on open-drain wires.
  Assumes the bench resolves both wires with pull-ups; 800 ns per bit.
*/
`timescale 1ns/1ns
module tws_master_model (
  // Resolved wires
  input wire logic i_scl,
  input wire logic i_sda,
  // Pull low while high
  output logic o_scl_oe,
  output logic o_sda_oe
);
  initial begin
    o_scl_oe = 1'b0;
    o_sda_oe = 1'b0;
  end
  // Long low phase leaves the slave room after its synchroniser delay
  task automatic bit_io(input logic b, output logic s);
    o_sda_oe = !b;
    #400;
    o_scl_oe = 1'b0;
    // Stretching: the high phase counts from the wire's rise
    wait (i_scl);
    #100;
    s = i_sda;
    #100;
    o_scl_oe = 1'b1;
    #200;
  endtask
  task automatic start_cond();
    o_sda_oe = 1'b0;
    #400;
    o_scl_oe = 1'b0;
    wait (i_scl);
    #300;
    o_sda_oe = 1'b1;
    #300;
    o_scl_oe = 1'b1;
    #200;
  endtask
  task automatic stop_cond();
    o_sda_oe = 1'b1;
    #400;
    o_scl_oe = 1'b0;
    wait (i_scl);
    #300;
    o_sda_oe = 1'b0;
    #800;
  endtask
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic recv_byte(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(!ack, s);
  endtask
endmodule // tws_master_model

// ---- tws_slave_tb.sv ----
/*
  Self-checking bench for the two-wire slave: registers and slave transfers.
  Assumes the master model, pull-ups on both wires and the bound checker.
*/
`timescale 1ns/1ns
module tws_slave_tb;
  logic i_clock, i_rstn, i_wb_cyc, i_wb_stb, i_wb_we, i_sleep, i_arb_lost;
  logic [3:0] i_wb_sel, i_wb_adr;
  logic [31:0] i_wb_dat, o_wb_dat;
  logic o_wb_ack, o_scl_out, o_scl_oe, o_sda_out, o_sda_oe, o_wake, o_start_request;
  logic m_scl_oe, m_sda_oe, ak;
  logic [7:0] q, r;
  int fails, check_count, cyc_n;
  wire scl = !(o_scl_oe || m_scl_oe);
  wire sda = !(o_sda_oe || m_sda_oe);
  tws_slave #(.ADR_W(4)) dut (
    .i_clock, .i_rstn, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_sel, .i_wb_adr,
    .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_scl(scl), .o_scl_out, .o_scl_oe,
    .i_sda(sda), .o_sda_out, .o_sda_oe, .i_sleep, .i_arb_lost, .o_wake,
    .o_start_request);
  tws_master_model m (.i_scl(scl), .i_sda(sda), .o_scl_oe(m_scl_oe), .o_sda_oe(m_sda_oe));
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = !i_clock;
  end
  always @(posedge i_clock) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      fails++;
      final_report();
    end
  end
  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_clock);
    i_wb_cyc <= 1'b1;
    i_wb_stb <= 1'b1;
    i_wb_we <= w;
    i_wb_adr <= a;
    i_wb_dat <= {24'h0, d};
    @(posedge i_clock);
    while (o_wb_ack !== 1'b1 && n < 50) begin
      n++;
      @(posedge i_clock);
    end
    chk("bus ack", {7'h0, o_wb_ack}, 8'h01);
    q = o_wb_dat[7:0];
    i_wb_cyc <= 1'b0;
    i_wb_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
    wb(1'b0, a, 8'h00);
    chk(n, q, e);
  endtask
  task automatic ctl(input logic [7:0] v);
    wb(1'b1, tws_pkg::OFS_CONTROL, v);
  endtask
  // Polls the flag first, so a missing event shows as a wrong code
  task automatic stat(input logic [7:0] e);
    int n;
    n = 0;
    q = 8'h00;
    while (q[7] !== 1'b1 && n < 100) begin
      wb(1'b0, tws_pkg::OFS_CONTROL, 8'h00);
      n++;
    end
    rd(tws_pkg::OFS_STATUS, e, "status");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    i_rstn = 1'b0;
    i_wb_cyc = 1'b0;
    i_wb_stb = 1'b0;
    i_wb_we = 1'b0;
    i_wb_sel = 4'h1;
    i_wb_adr = 4'h0;
    i_wb_dat = 32'h0;
    i_sleep = 1'b0;
    i_arb_lost = 1'b0;
    repeat (16) @(posedge i_clock);
    i_rstn <= 1'b1;
    rd(tws_pkg::OFS_OWN_ADDR, 8'h00, "own address");
    rd(tws_pkg::OFS_STATUS, 8'hf8, "status");
    rd(tws_pkg::OFS_DATA, 8'hff, "data");
    rd(4'h2, 8'h00, "hole");
    wb(1'b1, tws_pkg::OFS_STATUS, 8'h03);
    rd(tws_pkg::OFS_STATUS, 8'hfb, "prescaler");
    wb(1'b1, tws_pkg::OFS_STATUS, 8'h00);
    wb(1'b1, tws_pkg::OFS_OWN_ADDR, 8'h55);
    ctl(8'h44);
    // Receiver: data, repeated start, general call, refusal
    m.start_cond();
    m.send_byte(8'h54, ak);
    chk("address ack", {7'h0, ak}, 8'h01);
    stat(8'h60);
    ctl(8'hc4);
    m.send_byte(8'ha5, ak);
    stat(8'h80);
    rd(tws_pkg::OFS_DATA, 8'ha5, "data");
    ctl(8'hc4);
    m.start_cond();
    stat(8'ha0);
    ctl(8'hc4);
    m.send_byte(8'h00, ak);
    stat(8'h70);
    ctl(8'hc4);
    m.send_byte(8'h11, ak);
    stat(8'h90);
    ctl(8'h84);
    m.send_byte(8'h22, ak);
    chk("data nack", {7'h0, ak}, 8'h00);
    stat(8'h98);
    rd(tws_pkg::OFS_DATA, 8'h22, "data");
    ctl(8'hc4);
    m.start_cond();
    m.send_byte(8'h54, ak);
    stat(8'h60);
    ctl(8'h84);
    m.send_byte(8'h3c, ak);
    stat(8'h88);
    rd(tws_pkg::OFS_DATA, 8'h3c, "data");
    ctl(8'h84);
    m.stop_cond();
    rd(tws_pkg::OFS_STATUS, 8'hf8, "status");
    m.start_cond();
    m.send_byte(8'h54, ak);
    chk("isolated", {7'h0, ak}, 8'h00);
    m.stop_cond();
    // Transmitter: last byte, overrun, lost arbitration, start request
    ctl(8'h44);
    wb(1'b1, tws_pkg::OFS_OWN_ADDR, 8'h54);
    m.start_cond();
    m.send_byte(8'h00, ak);
    chk("no general call", {7'h0, ak}, 8'h00);
    m.start_cond();
    m.send_byte(8'h55, ak);
    stat(8'ha8);
    wb(1'b1, tws_pkg::OFS_DATA, 8'h96);
    ctl(8'hc4);
    m.recv_byte(1'b1, r);
    chk("tx byte", r, 8'h96);
    stat(8'hb8);
    wb(1'b1, tws_pkg::OFS_DATA, 8'h5a);
    ctl(8'h84);
    m.recv_byte(1'b1, r);
    chk("tx byte", r, 8'h5a);
    stat(8'hc8);
    ctl(8'hc4);
    m.recv_byte(1'b0, r);
    chk("released", r, 8'hff);
    m.start_cond();
    @(posedge i_clock);
    i_arb_lost <= 1'b1;
    m.send_byte(8'h55, ak);
    stat(8'hb0);
    @(posedge i_clock);
    i_arb_lost <= 1'b0;
    wb(1'b1, tws_pkg::OFS_DATA, 8'h81);
    ctl(8'h84);
    m.recv_byte(1'b0, r);
    stat(8'hc0);
    ctl(8'he4);
    chk("start held", {7'h0, o_start_request}, 8'h00);
    m.stop_cond();
    @(posedge i_clock);
    chk("start sent", {7'h0, o_start_request}, 8'h01);
    ctl(8'h44);
    // Sleep: a match wakes and holds the clock until the flag clears
    @(posedge i_clock);
    i_sleep <= 1'b1;
    m.start_cond();
    m.send_byte(8'h54, ak);
    stat(8'h60);
    chk("wake", {6'h0, o_wake, o_scl_oe}, 8'h03);
    rd(tws_pkg::OFS_DATA, 8'h81, "data after wake");
    ctl(8'hc4);
    repeat (2) @(posedge i_clock);
    chk("wake", {6'h0, o_wake, o_scl_oe}, 8'h00);
    i_sleep <= 1'b0;
    m.stop_cond();
    stat(8'ha0);
    ctl(8'hc4);
    final_report();
  end
endmodule // tws_slave_tb
